//--- common/crad_pkg.sv
// Notes on behaviour
// - Clear clock write bit: read control byte, AND with 0x7f, write back.
// - Set clock read bit: read control byte, OR with 0x40, write back.
// - Clear clock read bit: read control byte, AND with 0xbf, write back.
// - Inverting A10 moves clock bytes from 7F8-7FF to 3F8-3FF.
// - Any subset of the eight upper device address lines may be inverted.
// - Chip enables decode from host lines above A10; clock bytes stay consecutive.
// - A port bit drives a pseudo address line that joins device selection.
// - I/O request strobe selects the port chip and disables all memory.
// - Master and three slaves each get a 2K window, clock bytes on top.
// - I/O map: menu preset 0000, data preset 0001, display 0002.
// - Memory write strobe is blocked while system reset is asserted.
// - Execute button raises an event; the menu preset is then read.
// - Separate memory and I/O data transceivers share the processor data bus.
package crad_pkg;

  localparam logic [7:0]  OFF_CMD     = 8'h00;
  localparam logic [7:0]  OFF_ADDR    = 8'h04;
  localparam logic [7:0]  OFF_WDATA   = 8'h08;
  localparam logic [7:0]  OFF_STAT    = 8'h0c;
  localparam logic [7:0]  OFF_RDATA   = 8'h10;
  localparam logic [7:0]  OFF_CFG     = 8'h14;
  localparam logic [7:0]  OFF_MENU    = 8'h18;

  localparam int          ST_BUSY     = 0;
  localparam int          ST_DONE     = 1;
  localparam int          ST_EXEC     = 2;
  localparam int          ST_ERR      = 3;
  localparam int          CFG_INV_LSB = 0;
  localparam int          CFG_BANK_EN = 8;
  localparam int          CFG_BANK    = 9;
  localparam logic [9:0]  CFG_RST     = 10'h000;

  localparam logic [10:0] CTRL_OFF    = 11'h7f8;
  localparam logic [7:0]  SET_W_MASK  = 8'h80;
  localparam logic [7:0]  CLR_W_MASK  = 8'h7f;
  localparam logic [7:0]  SET_R_MASK  = 8'h40;
  localparam logic [7:0]  CLR_R_MASK  = 8'hbf;

  localparam int          WIN_LSB     = 11;
  localparam logic [2:0]  DEV_BASE    = 3'h0;
  localparam logic [15:0] IO_MENU     = 16'h0000;
  localparam logic [15:0] IO_DATA     = 16'h0001;
  localparam logic [15:0] IO_DISP     = 16'h0002;

  localparam int          CLK_NS      = 100;
  localparam int          ACC_NS      = 250;
  localparam logic [2:0]  ACC_CYC     = 3'((ACC_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [2:0] {
    CMD_MRD, CMD_MWR, CMD_SETW, CMD_CLRW, CMD_SETR, CMD_CLRR, CMD_IORD, CMD_IOWR
  } crad_cmd_t;

  typedef enum logic [1:0] {S_IDLE, S_RUN, S_WAIT} crad_seq_t;
  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_RECOV} crad_cyc_t;

  typedef struct packed {
    logic        wr;
    logic        io;
    logic [15:0] addr;
    logic [7:0]  data;
  } crad_req_t;

  typedef struct packed {
    logic [10:0] addr;
    logic [7:0]  dq;
    logic        dq_oe;
    logic [3:0]  ce_n;
    logic        oe_n;
    logic        we_n;
    logic        iorq_n;
    logic        port_cs_n;
    logic        mem_buf_en;
    logic        io_buf_en;
  } crad_pins_t;

  localparam crad_pins_t PINS_IDLE = '{addr: 11'h000, dq: 8'h00, dq_oe: 1'b0,
                                       ce_n: 4'hf, oe_n: 1'b1, we_n: 1'b1,
                                       iorq_n: 1'b1, port_cs_n: 1'b1,
                                       mem_buf_en: 1'b0, io_buf_en: 1'b0};

endpackage

//--- design/crad_cycle.sv
`timescale 1ns/10ps
module crad_cycle (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                start,
  input  wire crad_pkg::crad_req_t req,
  input  wire logic [10:0]         dev_addr,
  input  wire logic [3:0]          ce_sel,
  input  wire logic                port_sel,
  input  wire logic [7:0]          dq_in,
  output crad_pkg::crad_pins_t     pins,
  output logic                     done,
  output logic      [7:0]          rdata
);
  import crad_pkg::*;

  crad_cyc_t  st_reg,    st_next;
  crad_pins_t pins_reg,  pins_next;
  logic [2:0] cnt_reg,   cnt_next;
  logic       wr_reg,    wr_next;
  logic       done_reg,  done_next;
  logic [7:0] rdata_reg, rdata_next;

  always_comb begin
    st_next    = st_reg;
    pins_next  = pins_reg;
    cnt_next   = cnt_reg;
    wr_next    = wr_reg;
    done_next  = 1'b0;
    rdata_next = rdata_reg;
    unique case (st_reg)
      C_IDLE: begin
        if (start) begin
          pins_next            = PINS_IDLE;
          pins_next.addr       = req.io ? {9'h000, req.addr[1:0]} : dev_addr;
          pins_next.ce_n       = ~ce_sel;
          pins_next.iorq_n     = !req.io;
          pins_next.port_cs_n  = !port_sel;
          pins_next.mem_buf_en = !req.io;
          pins_next.io_buf_en  = req.io;
          pins_next.dq         = req.data;
          pins_next.dq_oe      = req.wr;
          wr_next              = req.wr;
          st_next              = C_SETUP;
        end
      end
      C_SETUP: begin
        if (wr_reg) begin
          pins_next.we_n = 1'b0;
        end else begin
          pins_next.oe_n = 1'b0;
        end
        cnt_next = ACC_CYC - 3'h1;
        st_next  = C_STROBE;
      end
      C_STROBE: begin
        if (cnt_reg == 3'h0) begin
          if (!wr_reg) begin
            rdata_next = dq_in;
          end
          pins_next.oe_n = 1'b1;
          pins_next.we_n = 1'b1;
          st_next        = C_RECOV;
        end else begin
          cnt_next = cnt_reg - 3'h1;
        end
      end
      C_RECOV: begin
        pins_next = PINS_IDLE;
        done_next = 1'b1;
        st_next   = C_IDLE;
      end
    endcase
  end

  // Reset holds every strobe inactive, so no write can reach a device
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg    <= C_IDLE;
      pins_reg  <= PINS_IDLE;
      cnt_reg   <= 3'h0;
      wr_reg    <= 1'b0;
      done_reg  <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      st_reg    <= st_next;
      pins_reg  <= pins_next;
      cnt_reg   <= cnt_next;
      wr_reg    <= wr_next;
      done_reg  <= done_next;
      rdata_reg <= rdata_next;
    end
  end

  assign pins  = pins_reg;
  assign done  = done_reg;
  assign rdata = rdata_reg;

endmodule

//--- design/crad_decode.sv
`timescale 1ns/10ps
module crad_decode (
  input  wire crad_pkg::crad_req_t req,
  input  wire logic [7:0]          inv_mask,
  input  wire logic                bank_en,
  input  wire logic                bank_line,
  output logic      [10:0]         dev_addr,
  output logic      [3:0]          ce_sel,
  output logic                     port_sel,
  output logic                     hit
);
  import crad_pkg::*;

  logic win_ok;

  always_comb begin
    dev_addr = {req.addr[10:3] ^ inv_mask, req.addr[2:0]};
    win_ok   = (req.addr[15:13] == DEV_BASE) && (!bank_en || bank_line);
    ce_sel   = 4'h0;
    if (!req.io && win_ok) begin
      ce_sel = 4'h1 << req.addr[12:WIN_LSB];
    end
    port_sel = req.io && (req.addr <= IO_DISP);
    hit      = (ce_sel != 4'h0) || port_sel;
  end

endmodule

//--- design/crad_top.sv
`timescale 1ns/10ps
module crad_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        exec_btn,
  input  wire logic [7:0]  dq_in,
  output logic      [7:0]  dq_out,
  output logic             dq_oe,
  output logic      [10:0] mem_addr,
  output logic      [3:0]  ce_n,
  output logic             oe_n,
  output logic             we_n,
  output logic             io_request_strobe_n,
  output logic             port_cs_n,
  output logic             mem_buf_en,
  output logic             io_buf_en,
  output logic             bank_line
);
  import crad_pkg::*;

  // Bus slave state
  logic        pready_reg,  pready_next;
  logic        pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg,  prdata_next;
  logic [15:0] addr_reg,    addr_next;
  logic [7:0]  wdata_reg,   wdata_next;
  logic [9:0]  cfg_reg,     cfg_next;
  logic        done_reg,    done_next;
  logic        exec_reg,    exec_next;
  logic        err_reg,     err_next;
  logic        btn_reg,     btn_next;
  logic        menu_pend_reg, menu_pend_next;
  logic [7:0]  rd_reg,      rd_next;
  logic [7:0]  menu_reg,    menu_next;

  // Sequencer state
  crad_seq_t   seq_reg,     seq_next;
  crad_cmd_t   cmd_reg,     cmd_next;
  crad_req_t   req_reg,     req_next;
  logic        rmw_reg,     rmw_next;
  logic        auto_reg,    auto_next;
  logic        start_reg,   start_next;

  logic        acc;
  logic        unmapped;
  logic        cmd_go;
  logic        exec_rise;
  logic        take_menu;
  logic        done_set;
  logic        err_set;
  crad_cmd_t   cmd_w;

  logic [10:0] dev_addr;
  logic [3:0]  ce_sel;
  logic        port_sel;
  logic        hit;
  logic        cyc_done;
  logic [7:0]  cyc_rdata;
  crad_pins_t  pins;

  function automatic logic [7:0] modify(input crad_cmd_t c, input logic [7:0] v);
    case (c)
      CMD_SETW: modify = v | SET_W_MASK;
      CMD_CLRW: modify = v & CLR_W_MASK;
      CMD_SETR: modify = v | SET_R_MASK;
      CMD_CLRR: modify = v & CLR_R_MASK;
      default:  modify = v;
    endcase
  endfunction

  crad_decode u_decode (
    .req       (req_reg),
    .inv_mask  (cfg_reg[CFG_INV_LSB +: 8]),
    .bank_en   (cfg_reg[CFG_BANK_EN]),
    .bank_line (cfg_reg[CFG_BANK]),
    .dev_addr  (dev_addr),
    .ce_sel    (ce_sel),
    .port_sel  (port_sel),
    .hit       (hit)
  );

  crad_cycle u_cycle (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (start_reg),
    .req      (req_reg),
    .dev_addr (dev_addr),
    .ce_sel   (ce_sel),
    .port_sel (port_sel),
    .dq_in    (dq_in),
    .pins     (pins),
    .done     (cyc_done),
    .rdata    (cyc_rdata)
  );

  // Request sequencer, with read-modify-write of the control byte
  always_comb begin
    seq_next   = seq_reg;
    cmd_next   = cmd_reg;
    req_next   = req_reg;
    rmw_next   = rmw_reg;
    auto_next  = auto_reg;
    start_next = 1'b0;
    take_menu  = 1'b0;
    done_set   = 1'b0;
    err_set    = 1'b0;
    rd_next    = rd_reg;
    menu_next  = menu_reg;
    unique case (seq_reg)
      S_IDLE: begin
        if (menu_pend_reg) begin
          req_next  = '{wr: 1'b0, io: 1'b1, addr: IO_MENU, data: 8'h00};
          auto_next = 1'b1;
          rmw_next  = 1'b0;
          take_menu = 1'b1;
          seq_next  = S_RUN;
        end else if (cmd_go) begin
          cmd_next     = cmd_w;
          auto_next    = 1'b0;
          rmw_next     = cmd_w inside {CMD_SETW, CMD_CLRW, CMD_SETR, CMD_CLRR};
          req_next.wr  = (cmd_w == CMD_MWR) || (cmd_w == CMD_IOWR);
          req_next.io  = (cmd_w == CMD_IORD) || (cmd_w == CMD_IOWR);
          req_next.data = wdata_reg;
          req_next.addr = addr_reg;
          if (cmd_w inside {CMD_SETW, CMD_CLRW, CMD_SETR, CMD_CLRR}) begin
            req_next.addr = {addr_reg[15:WIN_LSB], CTRL_OFF};
          end
          seq_next = S_RUN;
        end
      end
      S_RUN: begin
        if (!hit) begin
          err_set  = 1'b1;
          done_set = 1'b1;
          seq_next = S_IDLE;
        end else begin
          start_next = 1'b1;
          seq_next   = S_WAIT;
        end
      end
      S_WAIT: begin
        if (cyc_done) begin
          if (rmw_reg) begin
            rmw_next      = 1'b0;
            req_next.wr   = 1'b1;
            req_next.data = modify(cmd_reg, cyc_rdata);
            seq_next      = S_RUN;
          end else begin
            rd_next  = req_reg.wr ? req_reg.data : cyc_rdata;
            if (auto_reg) begin
              menu_next = cyc_rdata;
            end
            done_set = 1'b1;
            seq_next = S_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_reg   <= S_IDLE;
      cmd_reg   <= CMD_MRD;
      req_reg   <= '0;
      rmw_reg   <= 1'b0;
      auto_reg  <= 1'b0;
      start_reg <= 1'b0;
      rd_reg    <= 8'h00;
      menu_reg  <= 8'h00;
    end else begin
      seq_reg   <= seq_next;
      cmd_reg   <= cmd_next;
      req_reg   <= req_next;
      rmw_reg   <= rmw_next;
      auto_reg  <= auto_next;
      start_reg <= start_next;
      rd_reg    <= rd_next;
      menu_reg  <= menu_next;
    end
  end

  // APB slave: one wait state, then pready with registered data
  always_comb begin
    acc       = psel && penable && pready_reg;
    unmapped  = !(paddr inside {OFF_CMD, OFF_ADDR, OFF_WDATA, OFF_STAT,
                                OFF_RDATA, OFF_CFG, OFF_MENU});
    cmd_w     = crad_cmd_t'(pwdata[2:0]);
    cmd_go    = acc && pwrite && (paddr == OFF_CMD) && (seq_reg == S_IDLE);
    exec_rise = exec_btn && !btn_reg;

    pready_next  = psel && penable && !pready_reg;
    pslverr_next = pready_next && unmapped;
    prdata_next  = 32'h0000_0000;
    unique case (paddr)
      OFF_ADDR:  prdata_next = {16'h0000, addr_reg};
      OFF_WDATA: prdata_next = {24'h000000, wdata_reg};
      OFF_STAT:  prdata_next = {28'h0000000, err_reg, exec_reg, done_reg,
                                seq_reg != S_IDLE};
      OFF_RDATA: prdata_next = {24'h000000, rd_reg};
      OFF_CFG:   prdata_next = {22'h000000, cfg_reg};
      OFF_MENU:  prdata_next = {24'h000000, menu_reg};
      default:   prdata_next = 32'h0000_0000;
    endcase
    if (!pready_next || pwrite) begin
      prdata_next = 32'h0000_0000;
    end

    addr_next      = addr_reg;
    wdata_next     = wdata_reg;
    cfg_next       = cfg_reg;
    btn_next       = exec_btn;
    done_next      = done_reg;
    exec_next      = exec_reg;
    err_next       = err_reg;
    if (acc && pwrite) begin
      unique case (paddr)
        OFF_ADDR:  addr_next  = pwdata[15:0];
        OFF_WDATA: wdata_next = pwdata[7:0];
        OFF_CFG:   cfg_next   = pwdata[9:0];
        OFF_STAT: begin
          done_next = done_reg & ~pwdata[ST_DONE];
          exec_next = exec_reg & ~pwdata[ST_EXEC];
          err_next  = err_reg & ~pwdata[ST_ERR];
        end
        default: begin
        end
      endcase
    end
    if (acc && pwrite && (paddr == OFF_CMD) && (seq_reg != S_IDLE)) begin
      err_next = 1'b1;
    end
    if (done_set) begin
      done_next = 1'b1;
    end
    if (err_set) begin
      err_next = 1'b1;
    end
    if (exec_rise) begin
      exec_next = 1'b1;
    end
    menu_pend_next = exec_rise || (menu_pend_reg && !take_menu);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg    <= 1'b0;
      pslverr_reg   <= 1'b0;
      prdata_reg    <= 32'h0000_0000;
      addr_reg      <= 16'h0000;
      wdata_reg     <= 8'h00;
      cfg_reg       <= CFG_RST;
      btn_reg       <= 1'b0;
      done_reg      <= 1'b0;
      exec_reg      <= 1'b0;
      err_reg       <= 1'b0;
      menu_pend_reg <= 1'b0;
    end else begin
      pready_reg    <= pready_next;
      pslverr_reg   <= pslverr_next;
      prdata_reg    <= prdata_next;
      addr_reg      <= addr_next;
      wdata_reg     <= wdata_next;
      cfg_reg       <= cfg_next;
      btn_reg       <= btn_next;
      done_reg      <= done_next;
      exec_reg      <= exec_next;
      err_reg       <= err_next;
      menu_pend_reg <= menu_pend_next;
    end
  end

  assign prdata              = prdata_reg;
  assign pready              = pready_reg;
  assign pslverr             = pslverr_reg;
  assign dq_out              = pins.dq;
  assign dq_oe               = pins.dq_oe;
  assign mem_addr            = pins.addr;
  assign ce_n                = pins.ce_n;
  assign oe_n                = pins.oe_n;
  assign we_n                = pins.we_n;
  assign io_request_strobe_n = pins.iorq_n;
  assign port_cs_n           = pins.port_cs_n;
  assign mem_buf_en          = pins.mem_buf_en;
  assign io_buf_en           = pins.io_buf_en;
  assign bank_line           = cfg_reg[CFG_BANK];

endmodule

//--- verification/crad_asserts.sv
`timescale 1ns/10ps
module crad_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        dq_oe,
  input wire logic [10:0] mem_addr,
  input wire logic [3:0]  ce_n,
  input wire logic        oe_n,
  input wire logic        we_n,
  input wire logic        io_request_strobe_n,
  input wire logic        port_cs_n,
  input wire logic        mem_buf_en,
  input wire logic        io_buf_en
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ce_onehot: assert property ($onehot0(~ce_n))
    else $error("two chip enables active");
  a_io_no_ce: assert property (!io_request_strobe_n |-> ce_n == 4'hf && !mem_buf_en)
    else $error("memory selected in io cycle");
  a_port_io: assert property (!port_cs_n |-> !io_request_strobe_n && io_buf_en)
    else $error("port chip selected outside io cycle");
  a_mem_buf: assert property (ce_n != 4'hf |-> mem_buf_en && !io_buf_en)
    else $error("wrong transceiver for memory");
  a_we_drive: assert property (!we_n |-> dq_oe)
    else $error("write strobe without data drive");
  a_rd_float: assert property (!oe_n |-> !dq_oe)
    else $error("host drives bus during read");
  a_we_len: assert property ($fell(we_n) |-> !we_n [*3] ##1 we_n)
    else $error("write strobe length wrong");
  a_addr_hold: assert property (!oe_n || !we_n |-> $stable(mem_addr) && $stable(ce_n))
    else $error("address moved under strobe");
  a_rst_quiet: assert property ($rose(presetn) |-> we_n && ce_n == 4'hf)
    else $error("strobe active after reset");
  a_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("apb wait state count wrong");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_rdata_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  a_unmapped: assert property (pready && paddr > 8'h18 |-> pslverr)
    else $error("unmapped access not refused");
endmodule

bind crad_top crad_asserts u_asserts (.pclk, .presetn, .psel, .penable, .paddr, .prdata,
  .pready, .pslverr, .dq_oe, .mem_addr, .ce_n, .oe_n, .we_n, .io_request_strobe_n,
  .port_cs_n, .mem_buf_en, .io_buf_en);

//--- verification/crad_dev_model.sv
`timescale 1ns/10ps
module crad_dev_model (
  input  wire logic        pclk,
  input  wire logic [10:0] mem_addr,
  input  wire logic [3:0]  ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        io_request_strobe_n,
  input  wire logic        port_cs_n,
  input  wire logic        mem_buf_en,
  input  wire logic        io_buf_en,
  input  wire logic [7:0]  dq_out,
  input  wire logic        dq_oe,
  input  wire logic [7:0]  menu_val,
  input  wire logic [7:0]  data_val,
  output logic      [7:0]  dq_in,
  output logic      [7:0]  disp,
  output logic      [5:0]  cal
);
  logic [7:0]  mem [0:8191];
  logic [7:0]  last;
  logic [7:0]  rd_val;
  logic [12:0] idx;
  logic        mem_rd;
  logic        io_rd;
  initial begin
    for (int i = 0; i < 8192; i++) mem[i] = 8'(i) ^ 8'h5a;
    last = 8'h00;
    disp = 8'h00;
    cal  = 6'h00;
  end
  assign idx = {!ce_n[0] ? 2'd0 : !ce_n[1] ? 2'd1 : !ce_n[2] ? 2'd2 : 2'd3, mem_addr};
  assign mem_rd = !oe_n && ce_n != 4'hf && mem_buf_en;
  assign io_rd = !oe_n && !port_cs_n && !io_request_strobe_n && io_buf_en;
  assign rd_val = mem_rd ? mem[idx] : mem_addr[1:0] == 2'd0 ? menu_val :
                  mem_addr[1:0] == 2'd1 ? data_val : disp;
  // Released bus shows the inverse of the last byte
  assign dq_in = (mem_rd || io_rd) ? rd_val : ~last;
  always @(posedge pclk) begin
    if (mem_rd || io_rd) last <= rd_val;
  end
  always @(posedge we_n) begin
    if (ce_n != 4'hf && mem_buf_en && dq_oe) begin
      mem[idx] = dq_out;
      if (mem_addr == 11'h7f8 && dq_out[7]) cal = dq_out[5:0];
    end else if (!port_cs_n && io_buf_en && mem_addr[1:0] == 2'd2) begin
      disp = dq_out;
    end
  end
endmodule

//--- verification/tb_crad_top.sv
`timescale 1ns/10ps
module tb_crad_top;
  import crad_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, exec_btn;
  logic [7:0]  paddr, dq_in, dq_out, menu_val, data_val, disp, v, ev;
  logic [31:0] pwdata, prdata, r;
  logic        dq_oe, oe_n, we_n, io_request_strobe_n, port_cs_n, mem_buf_en;
  logic        io_buf_en, bank_line, e;
  logic [10:0] mem_addr;
  logic [3:0]  ce_n, st;
  logic [5:0]  cal;
  logic [9:0]  cfg;
  logic [15:0] ha;
  int          error_cnt, num_checks, seed;
  int          ref_mem [0:8191];

  crad_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .exec_btn, .dq_in, .dq_out, .dq_oe, .mem_addr, .ce_n, .oe_n,
    .we_n, .io_request_strobe_n, .port_cs_n, .mem_buf_en, .io_buf_en, .bank_line);
  crad_dev_model u_dev (.pclk, .mem_addr, .ce_n, .oe_n, .we_n, .io_request_strobe_n,
    .port_cs_n, .mem_buf_en, .io_buf_en, .dq_out, .dq_oe, .menu_val, .data_val,
    .dq_in, .disp, .cal);

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string s);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk_val(32'h0, 32'h1, "apb hang");
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    do begin apb(1'b0, OFF_STAT, 32'h0); n++; end while (r[ST_DONE] !== 1'b1 && n < 40);
    if (r[ST_DONE] !== 1'b1) chk_val(32'h0, 32'h1, "done timeout");
    st = r[3:0];
    apb(1'b1, OFF_STAT, 32'he);
    apb(1'b0, OFF_RDATA, 32'h0);
  endtask

  task automatic cmd(input crad_cmd_t c, input logic [15:0] a, input logic [7:0] d);
    apb(1'b1, OFF_ADDR, {16'h0, a});
    apb(1'b1, OFF_WDATA, {24'h0, d});
    apb(1'b1, OFF_CMD, {29'h0, c});
    wait_done();
  endtask

  task automatic set_cfg(input logic [9:0] c);
    cfg = c;
    apb(1'b1, OFF_CFG, {22'h0, c});
  endtask

  function automatic int ref_idx(input logic [15:0] a);
    return int'({a[12:11], a[10:3] ^ cfg[7:0], a[2:0]});
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial begin
    #3000000;
    chk_val(32'h0, 32'h1, "watchdog");
    finish_test();
  end

  initial begin
    seed = 56116;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; exec_btn = 1'b0; menu_val = 8'h00; data_val = 8'h00; cfg = 10'h000;
    for (int i = 0; i < 8192; i++) ref_mem[i] = (i ^ 'h5a) & 'hff;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_CFG, 32'h0);
    chk_val(r, 32'h0, "cfg reset");
    apb(1'b1, 8'h1c, 32'hffffffff);
    apb(1'b0, 8'h1c, 32'h0);
    chk_val({r[30:0], e}, 32'h1, "unmapped");
    $display("test registers done");
    for (int k = 0; k < 16; k++) begin
      set_cfg({2'b00, 8'($random(seed))});
      ha = {3'h0, 13'($random(seed))};
      v = 8'($random(seed));
      cmd(CMD_MWR, ha, v);
      ref_mem[ref_idx(ha)] = v;
      chk_val(32'(u_dev.mem[ref_idx(ha)]), 32'(v), "placed");
      cmd(CMD_MRD, ha ^ 16'h0001, 8'h00);
      chk_val(r, 32'(ref_mem[ref_idx(ha ^ 16'h0001)]), "read");
    end
    set_cfg(10'h080);
    cmd(CMD_MWR, 16'h03f8, 8'h3c);
    chk_val(32'(u_dev.mem[13'h07f8]), 32'h3c, "a10 inverted");
    $display("test decode done");
    set_cfg(10'h000);
    for (int c = 2; c < 6; c++) begin
      v = 8'($random(seed));
      cmd(CMD_MWR, {3'h0, 2'(c), 11'h7f8}, v);
      cmd(crad_cmd_t'(c), {3'h0, 2'(c), 11'h000}, 8'h00);
      ev = c == 2 ? v | 8'h80 : c == 3 ? v & 8'h7f : c == 4 ? v | 8'h40 : v & 8'hbf;
      chk_val(r, 32'(ev), "rmw");
      chk_val(32'(u_dev.mem[{2'(c), 11'h7f8}]), 32'(ev), "ctrl byte");
      if (c == 2) chk_val(32'(cal), 32'(ev[5:0]), "cal");
    end
    $display("test control done");
    menu_val <= 8'($random(seed));
    data_val <= 8'($random(seed));
    cmd(CMD_IORD, 16'h0001, 8'h00);
    chk_val(r, 32'(data_val), "data preset");
    cmd(CMD_IOWR, 16'h0002, 8'ha5);
    chk_val(32'(disp), 32'ha5, "display");
    cmd(CMD_IORD, 16'h0003, 8'h00);
    chk_val(32'(st[ST_ERR]), 32'h1, "io miss");
    set_cfg(10'h100);
    cmd(CMD_MRD, 16'h0010, 8'h00);
    chk_val(32'(st[ST_ERR]), 32'h1, "bank off");
    set_cfg(10'h300);
    cmd(CMD_MRD, 16'h0810, 8'h00);
    chk_val(r, 32'(ref_mem[ref_idx(16'h0810)]), "bank on");
    chk_val(32'(bank_line), 32'h1, "bank line");
    cmd(CMD_MWR, 16'h2000, 8'h11);
    chk_val(32'(st[ST_ERR]), 32'h1, "above map");
    $display("test io and bank done");
    menu_val <= 8'h37;
    exec_btn <= 1'b1;
    repeat (2) @(posedge pclk);
    exec_btn <= 1'b0;
    wait_done();
    chk_val(32'(st[ST_EXEC]), 32'h1, "exec");
    apb(1'b0, OFF_MENU, 32'h0);
    chk_val(r, 32'h37, "menu");
    apb(1'b1, OFF_ADDR, 32'h0000_0100);
    apb(1'b1, OFF_CMD, {29'h0, CMD_MWR});
    repeat (4) @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    chk_val(32'(we_n), 32'h1, "we in reset");
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_CFG, 32'h0);
    chk_val(r, 32'h0, "cfg after reset");
    $display("test exec and reset done");
    finish_test();
  end
endmodule
